// ### rtl/asr_consts.svh
/*
  Constants for the host controller of an asynchronous 128K x 8 static memory.
  Assumes a 200 MHz system clock; all counts except ASR_WREC_CYC derive from times in ns or ms.
*/
`ifndef ASR_CONSTS_SVH
`define ASR_CONSTS_SVH

`define ASR_ADDR_W          17
`define ASR_DATA_W          8
`define ASR_CNT_W           24
`define ASR_MON_W           8
`define ASR_CLK_NS          5
`define ASR_NS_PER_MS       1000000
`define ASR_CEIL_CYC(t)     (((t) + `ASR_CLK_NS - 1) / `ASR_CLK_NS)

// Cycle time, equal for read and write
`define ASR_T_RC_FAST_NS    100
`define ASR_T_RC_SLOW_NS    120
// Select and address to end of write
`define ASR_T_CW_FAST_NS    80
`define ASR_T_CW_SLOW_NS    85
// Write pulse
`define ASR_T_WP_FAST_NS    60
`define ASR_T_WP_SLOW_NS    65
// Data overlap before end of write
`define ASR_T_DW_FAST_NS    40
`define ASR_T_DW_SLOW_NS    45
// Output turn-off after gate rises
`define ASR_T_OHZ_FAST_NS   35
`define ASR_T_OHZ_SLOW_NS   40
// Recovery after retention
`define ASR_T_RET_MS        5
`define ASR_T_RET_SLOW_MS   50
// Idle cycles after strobe rises before deselect
`define ASR_WREC_CYC        1

`endif

// ### rtl/asr_pkg.sv
/*
  Types for the static memory host controller.
  Assumes asr_consts.svh is reachable on the include path.
*/
`include "asr_consts.svh"

package asr_pkg;

  typedef enum logic [6:0] {
    ASR_IDLE     = 7'h01,
    ASR_READ     = 7'h02,
    ASR_WR_GAP   = 7'h04,
    ASR_WR_PULSE = 7'h08,
    ASR_WR_REC   = 7'h10,
    ASR_RETAIN   = 7'h20,
    ASR_RECOVER  = 7'h40
  } asr_state_e;

  typedef struct packed {
    logic                    write;
    logic [`ASR_ADDR_W-1:0]  addr;
    logic [`ASR_DATA_W-1:0]  data;
  } asr_req_s;

  typedef struct packed {
    logic [`ASR_ADDR_W-1:0]  wordAddr;
    logic [`ASR_DATA_W-1:0]  dataOut;
    logic                    dataOe;
    logic                    selectLowActiveN;
    logic                    selectHighActive;
    logic                    writeStrobeN;
    logic                    outGateN;
  } asr_pins_s;

  typedef struct packed {
    asr_state_e              state;
    logic [`ASR_CNT_W-1:0]   cnt;
    asr_pins_s               pins;
    logic [`ASR_DATA_W-1:0]  rdData;
    logic                    rspValid;
    logic [`ASR_MON_W-1:0]   lowCnt;
    logic [`ASR_MON_W-1:0]   selCnt;
  } asr_regs_s;

endpackage : asr_pkg

// ### rtl/asr_host.sv
/*
  Host controller that drives an asynchronous 128K x 8 static memory
  through its pins, plus low-supply retention entry and recovery.
  Assumes memory data input is synchronous to clk_sys and that the
  testbench resolves the shared data wire from sramPins.dataOe.
*/
// Notes on behaviour
// - Write starts at last of three events
// - Write ends at first of three events
// - Host never drives against memory outputs
// - Gate low write needs longer pulse
// - Read and write cycle 100/120 ns
// - Address valid 80/85 ns before write end
// - Write pulse at least 60/65 ns
// - Selects active 80/85 ns before end
// - Data 40/45 ns before end, zero hold
// - Address may change at write end
// - High select low gates all inputs
// - Low select retention holds high select firm
// - Wait 5 ms, or 50 ms, after retention
`timescale 1ns/1ps
`default_nettype none

module asr_host
  import asr_pkg::*;
#(
  parameter bit                  SLOW_GRADE  = 1'b0,
  parameter logic [`ASR_CNT_W-1:0] RET_CYC   =
    `ASR_CNT_W'(`ASR_T_RET_MS * `ASR_NS_PER_MS / `ASR_CLK_NS),
  parameter logic [`ASR_CNT_W-1:0] RET_SLOW_CYC =
    `ASR_CNT_W'(`ASR_T_RET_SLOW_MS * `ASR_NS_PER_MS / `ASR_CLK_NS)
) (
  input  wire logic                   clk_sys,
  input  wire logic                   reset,
  input  wire logic                   ce,
  input  wire logic                   reqValid,
  output logic                        reqReady,
  input  wire asr_req_s               req,
  output logic                        rspValid,
  output logic [`ASR_DATA_W-1:0]      rspData,
  input  wire logic                   retainReq,
  input  wire logic                   supplyFastRise,
  output logic                        retainActive,
  output var asr_pins_s               sramPins,
  input  wire logic [`ASR_DATA_W-1:0] sramDataIn
);

  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  localparam int RC_NS  = SLOW_GRADE ? `ASR_T_RC_SLOW_NS  : `ASR_T_RC_FAST_NS;
  localparam int CW_NS  = SLOW_GRADE ? `ASR_T_CW_SLOW_NS  : `ASR_T_CW_FAST_NS;
  localparam int WP_NS  = SLOW_GRADE ? `ASR_T_WP_SLOW_NS  : `ASR_T_WP_FAST_NS;
  localparam int DW_NS  = SLOW_GRADE ? `ASR_T_DW_SLOW_NS  : `ASR_T_DW_FAST_NS;
  localparam int OHZ_NS = SLOW_GRADE ? `ASR_T_OHZ_SLOW_NS : `ASR_T_OHZ_FAST_NS;
  localparam int RC_CYC  = `ASR_CEIL_CYC(RC_NS);
  localparam int CW_CYC  = `ASR_CEIL_CYC(CW_NS);
  localparam int WP_CYC  = `ASR_CEIL_CYC(WP_NS);
  localparam int DW_CYC  = `ASR_CEIL_CYC(DW_NS);
  localparam int GAP_CYC = `ASR_CEIL_CYC(OHZ_NS);
  localparam int PW_CYC  = (CW_CYC > WP_CYC) ? CW_CYC : WP_CYC;

  asr_regs_s r_reg;
  asr_regs_s r_next;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    r_next          = r_reg;
    r_next.rspValid = 1'b0;
    // Monitors of strobe-low and selected time
    r_next.lowCnt = r_reg.pins.writeStrobeN ? '0 : r_reg.lowCnt + 1'b1;
    r_next.selCnt = (r_reg.pins.selectLowActiveN || !r_reg.pins.selectHighActive)
                    ? '0 : r_reg.selCnt + 1'b1;
    if (r_reg.cnt != '0) begin
      r_next.cnt = r_reg.cnt - 1'b1;
    end
    unique case (r_reg.state)
      ASR_IDLE: begin
        if (retainReq) begin
          // Both selects inactive; high select low gates every input
          r_next.pins.selectHighActive = 1'b0;
          r_next.pins.selectLowActiveN = 1'b1;
          r_next.pins.outGateN         = 1'b1;
          r_next.state                 = ASR_RETAIN;
        end else if (reqValid) begin
          r_next.pins.wordAddr         = req.addr;
          r_next.pins.selectLowActiveN = 1'b0;
          r_next.pins.selectHighActive = 1'b1;
          if (req.write) begin
            // Gate stays high so memory never drives during a write
            r_next.pins.outGateN = 1'b1;
            r_next.pins.dataOut  = req.data;
            r_next.cnt           = `ASR_CNT_W'(GAP_CYC - 1);
            r_next.state         = ASR_WR_GAP;
          end else begin
            r_next.pins.outGateN = 1'b0;
            r_next.cnt           = `ASR_CNT_W'(RC_CYC - 1);
            r_next.state         = ASR_READ;
          end
        end
      end
      ASR_READ: begin
        if (r_reg.cnt == '0) begin
          r_next.rdData                = sramDataIn;
          r_next.rspValid              = 1'b1;
          r_next.pins.outGateN         = 1'b1;
          r_next.pins.selectLowActiveN = 1'b1;
          r_next.pins.selectHighActive = 1'b0;
          r_next.state                 = ASR_IDLE;
        end
      end
      ASR_WR_GAP: begin
        // Wait for any prior read output to turn off before driving
        if (r_reg.cnt == '0) begin
          r_next.pins.writeStrobeN = 1'b0;
          r_next.pins.dataOe       = 1'b1;
          r_next.cnt               = `ASR_CNT_W'(PW_CYC - 1);
          r_next.state             = ASR_WR_PULSE;
        end
      end
      ASR_WR_PULSE: begin
        if (r_reg.cnt == '0) begin
          r_next.pins.writeStrobeN = 1'b1;
          r_next.cnt               = `ASR_CNT_W'(`ASR_WREC_CYC - 1);
          r_next.state             = ASR_WR_REC;
        end
      end
      ASR_WR_REC: begin
        if (r_reg.cnt == '0) begin
          r_next.pins.dataOe           = 1'b0;
          r_next.pins.selectLowActiveN = 1'b1;
          r_next.pins.selectHighActive = 1'b0;
          r_next.rspValid              = 1'b1;
          r_next.state                 = ASR_IDLE;
        end
      end
      ASR_RETAIN: begin
        if (!retainReq) begin
          r_next.cnt   = supplyFastRise ? RET_SLOW_CYC : RET_CYC;
          r_next.state = ASR_RECOVER;
        end
      end
      ASR_RECOVER: begin
        if (r_reg.cnt == '0) begin
          r_next.state = ASR_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r_reg                       <= '0;
      r_reg.state                 <= ASR_IDLE;
      r_reg.pins.selectLowActiveN <= 1'b1;
      r_reg.pins.writeStrobeN     <= 1'b1;
      r_reg.pins.outGateN         <= 1'b1;
    end else if (ce) begin
      r_reg <= r_next;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reqReady     = ce && (r_reg.state == ASR_IDLE) && !retainReq;
  assign rspValid     = r_reg.rspValid;
  assign rspData      = r_reg.rdData;
  assign retainActive = (r_reg.state == ASR_RETAIN) || (r_reg.state == ASR_RECOVER);
  assign sramPins     = r_reg.pins;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_NO_CONTENTION: assert property (@(posedge clk_sys) disable iff (reset)
    r_reg.pins.dataOe |-> r_reg.pins.outGateN)
    else $error("Host drives data while memory gate is low");

  AST_GATE_HIGH_IN_WRITE: assert property (@(posedge clk_sys) disable iff (reset)
    !r_reg.pins.writeStrobeN |-> r_reg.pins.outGateN && r_reg.pins.dataOe)
    else $error("Write pulse with gate low or data undriven");

  AST_WRITE_SELECTED: assert property (@(posedge clk_sys) disable iff (reset)
    !r_reg.pins.writeStrobeN |->
      !r_reg.pins.selectLowActiveN && r_reg.pins.selectHighActive)
    else $error("Write strobe low while not selected");

  AST_PULSE_WIDTH: assert property (@(posedge clk_sys) disable iff (reset)
    (r_reg.pins.writeStrobeN && !$past(r_reg.pins.writeStrobeN)) |->
      $past(r_reg.lowCnt) >= `ASR_MON_W'(PW_CYC - 1)
      && $past(r_reg.lowCnt) >= `ASR_MON_W'(WP_CYC - 1))
    else $error("Write pulse shorter than minimum");

  AST_SELECT_TO_END: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(r_reg.pins.writeStrobeN) |-> $past(r_reg.selCnt) >= `ASR_MON_W'(CW_CYC))
    else $error("Selects active too briefly before write end");

  AST_ADDR_DATA_STABLE: assert property (@(posedge clk_sys) disable iff (reset)
    (!r_reg.pins.writeStrobeN && !$past(r_reg.pins.writeStrobeN)) |->
      $stable(r_reg.pins.wordAddr) && $stable(r_reg.pins.dataOut))
    else $error("Address or data moved during write pulse");

  AST_DATA_OVERLAP: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(r_reg.pins.writeStrobeN) |-> $past(r_reg.lowCnt) >= `ASR_MON_W'(DW_CYC - 1))
    else $error("Write data overlap too short");

  AST_CYCLE_TIME: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(r_reg.pins.selectLowActiveN) |-> r_reg.selCnt >= `ASR_MON_W'(RC_CYC))
    else $error("Memory cycle shorter than minimum");

  AST_RETENTION_PINS: assert property (@(posedge clk_sys) disable iff (reset)
    (r_reg.state == ASR_RETAIN) |->
      !r_reg.pins.selectHighActive && r_reg.pins.selectLowActiveN && !reqReady)
    else $error("Retention entered with memory selected");

  AST_RECOVERY_WAIT: assert property (@(posedge clk_sys) disable iff (reset)
    (r_reg.state == ASR_RECOVER) |-> !reqReady && r_reg.pins.selectLowActiveN)
    else $error("Request accepted during retention recovery");

endmodule : asr_host

`default_nettype wire

// ### test/asr_sram_model.sv
/*
  Behavioural model of the 128K x 8 static memory on the far side of the host.
  Assumes host pins arrive as asr_pins_s; clk_sys only times read data settling.
*/
`timescale 1ns/1ps
`default_nettype none

module asr_sram_model
  import asr_pkg::*;
(
  input  wire logic      clk_sys,
  input  wire asr_pins_s pins,
  output logic [7:0]     busLevel,
  output logic           memDrive
);
  // ----------------------------------------------------------------
  // Storage and pin decode
  // ----------------------------------------------------------------
  logic [7:0] mem [0:131071];
  logic [7:0] gateLowCyc;
  logic       wrAct;

  assign wrAct = !pins.selectLowActiveN && pins.selectHighActive
                 && !pins.writeStrobeN;
  assign memDrive = !pins.selectLowActiveN && pins.selectHighActive
                    && pins.writeStrobeN && !pins.outGateN;

  // Store at the first release of select or strobe
  always @(negedge wrAct) mem[pins.wordAddr] = pins.dataOut;

  // Read data settles only 50 ns after the gate falls
  always @(posedge clk_sys) gateLowCyc <= memDrive ? gateLowCyc + 8'h01 : 8'h00;

  // Undriven or unsettled bus shows the inverse of the stored byte
  assign busLevel = pins.dataOe ? pins.dataOut
                  : (memDrive && gateLowCyc >= 8'h0a) ? mem[pins.wordAddr]
                  : ~mem[pins.wordAddr];
endmodule : asr_sram_model

`default_nettype wire

// ### test/test_asr_host.sv
/*
  Self-checking testbench for asr_host with the memory model attached.
  Assumes the fast grade and shortened retention recovery counts.
*/
`timescale 1ns/1ps
`default_nettype none

module test_asr_host;
  import asr_pkg::*;
  localparam int RET      = 20;
  localparam int RET_SLOW = 40;

  logic       clk_sys = 1'b0;
  logic       reset = 1'b1;
  logic       reqValid = 1'b0;
  logic       retainReq = 1'b0;
  logic       supplyFastRise = 1'b0;
  logic       ce = 1'b1;
  logic       reqReady, rspValid, retainActive, memDrive;
  logic [7:0] rspData, busLevel;
  asr_req_s   req = '0;
  asr_pins_s  sramPins;
  int         n_fail = 0;
  int         samples_checked = 0;

  initial forever #2.5 clk_sys = ~clk_sys;

  asr_host #(.SLOW_GRADE(1'b0), .RET_CYC(24'(RET)), .RET_SLOW_CYC(24'(RET_SLOW))) i_asr_host (
    .clk_sys(clk_sys), .reset(reset), .ce(ce), .reqValid(reqValid), .reqReady(reqReady),
    .req(req), .rspValid(rspValid), .rspData(rspData), .retainReq(retainReq),
    .supplyFastRise(supplyFastRise), .retainActive(retainActive), .sramPins(sramPins),
    .sramDataIn(busLevel));

  asr_sram_model i_asr_sram_model (
    .clk_sys(clk_sys), .pins(sramPins), .busLevel(busLevel), .memDrive(memDrive));

  // ----------------------------------------------------------------
  // Compare and closing
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test();
    $display("checks %0d failures %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // Host must never drive while memory drives
  always @(posedge clk_sys) if (!reset && sramPins.dataOe === 1'b1 && memDrive !== 1'b0)
    chk(32'h1, 32'h0);

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic access(input logic wr, input logic [16:0] a, input logic [7:0] d,
                        input int lat, input int stall = 0);
    int k;
    int lowCnt;
    int selCnt;
    lowCnt = 0;
    selCnt = 0;
    @(negedge clk_sys);
    reqValid = 1'b1;
    req = '{write: wr, addr: a, data: d};
    for (k = 0; k < 100 && reqReady !== 1'b1; k++) @(negedge clk_sys);
    if (k >= 100) begin
      chk(k, 0);
      finish_test();
    end
    @(posedge clk_sys);
    for (k = 1; k <= 200; k++) begin
      @(negedge clk_sys);
      reqValid = 1'b0;
      // Freeze the host for stall edges early in the access
      ce = (k < 3 || k >= 3 + stall);
      if (sramPins.writeStrobeN === 1'b0) lowCnt++;
      if (!sramPins.selectLowActiveN && sramPins.selectHighActive
          && (lowCnt == 0 || !sramPins.writeStrobeN)) selCnt++;
      if (rspValid === 1'b1) break;
    end
    chk(k, lat);
    if (k > 200) finish_test();
    else if (wr) begin
      chk(32'(lowCnt >= 12), 1);
      chk(32'(selCnt >= 16), 1);
    end else begin
      chk(rspData, d);
    end
  endtask : access

  task automatic retain(input logic slow, input int waitCyc);
    int k;
    @(negedge clk_sys);
    retainReq = 1'b1;
    supplyFastRise = slow;
    repeat (3) @(negedge clk_sys);
    chk(sramPins.selectHighActive, 0);
    chk(sramPins.selectLowActiveN, 1);
    chk(reqReady, 0);
    chk(retainActive, 1);
    retainReq = 1'b0;
    for (k = 0; k < 200 && reqReady !== 1'b1; k++) @(negedge clk_sys);
    chk(32'(k >= waitCyc && k <= waitCyc + 2), 1);
    if (k >= 200) finish_test();
  endtask : retain

  initial begin
    repeat (12) @(negedge clk_sys);
    reset = 1'b0;
    access(1'b1, 17'h00000, 8'ha5, 25);
    access(1'b1, 17'h1ffff, 8'h3c, 25);
    access(1'b0, 17'h00000, 8'ha5, 21);
    access(1'b0, 17'h1ffff, 8'h3c, 21);
    access(1'b0, 17'h00000, 8'ha5, 26, 5);
    access(1'b1, 17'h1ffff, 8'h5c, 25);
    retain(1'b0, RET);
    retain(1'b1, RET_SLOW);
    access(1'b0, 17'h1ffff, 8'h5c, 21);
    finish_test();
  end
endmodule : test_asr_host

`default_nettype wire
